/* shared/cism_pkg.sv */
// constants and types shared by the can interrupt status and mask block
package cism_pkg;
  localparam int NUM_SLOTS = 16;
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  // register indices; byte address is four times the index
  localparam logic [31:0] SLOT_FLAGS_IDX = 32'h0080100C;
  localparam logic [31:0] SLOT_EN_IDX = 32'h00801010;
  localparam logic [31:0] ERR_FLAGS_IDX = 32'h00801014;
  localparam logic [31:0] ERR_EN_IDX = 32'h00801015;
  localparam logic [31:0] SLOT_FLAGS_ADDR = {SLOT_FLAGS_IDX[29:0], 2'h0};
  localparam logic [31:0] SLOT_EN_ADDR = {SLOT_EN_IDX[29:0], 2'h0};
  localparam logic [31:0] ERR_FLAGS_ADDR = {ERR_FLAGS_IDX[29:0], 2'h0};
  localparam logic [31:0] ERR_EN_ADDR = {ERR_EN_IDX[29:0], 2'h0};
  // field positions
  localparam int BUS_ERR_FLAG_BIT = 5;
  localparam int ERR_PASSIVE_FLAG_BIT = 6;
  localparam int BUS_OFF_FLAG_BIT = 7;
  localparam int BUS_ERR_EN_BIT = 13;
  localparam int ERR_PASSIVE_EN_BIT = 14;
  localparam int BUS_OFF_EN_BIT = 15;
  // reset values
  localparam logic [15:0] SLOT_FLAGS_RST = 16'h0000;
  localparam logic [15:0] SLOT_EN_RST = 16'h0000;
  localparam logic [2:0] ERR_FLAGS_RST = 3'h0;
  localparam logic [2:0] ERR_EN_RST = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    CISM_ERR_ACTIVE = 2'b00,
    CISM_ERR_PASSIVE = 2'b01,
    CISM_BUS_OFF = 2'b10
  } cism_err_state_t;
  typedef enum logic [2:0] {
    CISM_REG_NONE = 3'b000,
    CISM_REG_SLOT_FLAGS = 3'b001,
    CISM_REG_SLOT_EN = 3'b010,
    CISM_REG_ERR_FLAGS = 3'b011,
    CISM_REG_ERR_EN = 3'b100
  } cism_reg_sel_t;
endpackage

/* verif/cism_checker.sv */
// concurrent checks on the ports of the can interrupt status and mask block
`timescale 1ns/100ps
module cism_checker
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [15:0] slot_tx_done, // send pulses
  input wire logic [15:0] slot_rx_stored, // store pulses
  input wire logic bus_error_pulse, // bus error
  input wire cism_pkg::cism_err_state_t err_state, // state
  input wire logic irq_slot, // slot request
  input wire logic irq_error, // error request
  input wire logic irq // any request
);
  import cism_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  a_irq_combined: assert property (irq == (irq_slot || irq_error))
    else $error("combined request wrong");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_slot_irq_cause: assert property ($rose(irq_slot) |->
    (|$past(slot_tx_done)) || (|$past(slot_rx_stored)) || $rose(s_axi_bvalid))
    else $error("slot request without cause");
  a_err_irq_cause: assert property ($rose(irq_error) |->
    $past(bus_error_pulse) || ($past(err_state) != $past(err_state, 2)) || $rose(s_axi_bvalid))
    else $error("error request without cause");
  a_irq_only_cleared: assert property ($fell(irq_slot) || $fell(irq_error) |-> s_wr_done)
    else $error("request fell without write");
endmodule // cism_checker

/* verif/cism_engine_model.sv */
// protocol engine model issuing completion and error events
`timescale 1ns/100ps
module cism_engine_model
(
  input wire logic aclk, // clock
  output logic [15:0] slot_tx_done, // send finished
  output logic [15:0] slot_rx_stored, // store finished
  output logic bus_error_pulse, // bus error
  output cism_pkg::cism_err_state_t err_state // state level
);
  import cism_pkg::*;
  initial
  begin
    slot_tx_done = 16'h0000;
    slot_rx_stored = 16'h0000;
    bus_error_pulse = 1'b0;
    err_state = CISM_ERR_ACTIVE;
  end
  // one-cycle pulse: 0 send, 1 stored, 2 bus error
  task automatic ev(input int k, input logic [15:0] m);
    @(posedge aclk);
    if (k == 0) slot_tx_done <= m;
    if (k == 1) slot_rx_stored <= m;
    if (k == 2) bus_error_pulse <= 1'b1;
    @(posedge aclk);
    slot_tx_done <= 16'h0000;
    slot_rx_stored <= 16'h0000;
    bus_error_pulse <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic st(input cism_err_state_t s);
    @(posedge aclk);
    err_state <= s;
    @(posedge aclk);
    @(negedge aclk);
  endtask
endmodule // cism_engine_model

/* verif/testbench.sv */
// self-checking bench for the can interrupt status and mask block
`timescale 1ns/100ps
bind cism_top cism_checker cism_checker_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .slot_tx_done(slot_tx_done), .slot_rx_stored(slot_rx_stored),
  .bus_error_pulse(bus_error_pulse), .err_state(err_state), .irq_slot(irq_slot), .irq_error(irq_error), .irq(irq));
module testbench;
  import cism_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, q;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_slot, irq_error, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] slot_is_tx = '0, slot_is_remote = '0, slot_auto_resp = '0, slot_tx_done, slot_rx_stored;
  logic bus_error_pulse;
  cism_err_state_t err_state;
  int fails = 0, checks = 0, cyc = 0;
  always #4 aclk = ~aclk;
  cism_top cism_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .slot_is_tx(slot_is_tx), .slot_is_remote(slot_is_remote),
    .slot_auto_resp(slot_auto_resp), .slot_tx_done(slot_tx_done), .slot_rx_stored(slot_rx_stored),
    .bus_error_pulse(bus_error_pulse), .err_state(err_state), .irq_slot(irq_slot), .irq_error(irq_error), .irq(irq));
  cism_engine_model cism_engine_model_inst (.aclk(aclk), .slot_tx_done(slot_tx_done),
    .slot_rx_stored(slot_rx_stored), .bus_error_pulse(bus_error_pulse), .err_state(err_state));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // drives on a rising edge; readies and answer read mid-cycle, where they stand until the next rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dd);
    logic ta, tw, tr, tk;
    @(posedge aclk);
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tk = w ? s_axi_bvalid : s_axi_rvalid;
      r = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    while (!tk);
    if (w) s_axi_bready <= 1'b0;
    else s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dd);
    bus(1'b1, a, dd);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic t_reset;
    rc(SLOT_FLAGS_ADDR, 32'h0);
    rc(SLOT_EN_ADDR, 32'h0);
    rc(ERR_FLAGS_ADDR, 32'h0);
    rc(32'h00000008, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
  endtask
  task automatic t_slots;
    @(posedge aclk);
    slot_is_tx <= 16'h0008;
    cism_engine_model_inst.ev(0, 16'h0028);
    cism_engine_model_inst.ev(1, 16'h0028);
    rc(SLOT_FLAGS_ADDR, 32'h0028);
    chk({31'h0, irq_slot}, 32'h0);
    wr(SLOT_EN_ADDR, 32'h0020);
    chk({31'h0, irq}, 32'h1);
    wr(SLOT_FLAGS_ADDR, 32'hFFDF);
    chk({31'h0, irq_slot}, 32'h0);
    rc(SLOT_FLAGS_ADDR, 32'h0008);
  endtask
  task automatic t_remote;
    @(posedge aclk);
    slot_is_tx <= 16'h0200;
    slot_is_remote <= 16'h0280;
    slot_auto_resp <= 16'h0080;
    cism_engine_model_inst.ev(0, 16'h0280);
    rc(SLOT_FLAGS_ADDR, 32'h0288);
    wr(SLOT_FLAGS_ADDR, 32'hFD77);
    cism_engine_model_inst.ev(1, 16'h0280);
    rc(SLOT_FLAGS_ADDR, 32'h0280);
  endtask
  task automatic t_race;
    fork
      wr(SLOT_FLAGS_ADDR, 32'hFD7F);
      begin
        @(negedge aclk iff (s_axi_awvalid && s_axi_awready));
        cism_engine_model_inst.ev(1, 16'h0080);
      end
    join
    rc(SLOT_FLAGS_ADDR, 32'h0080);
  endtask
  task automatic t_err;
    cism_engine_model_inst.ev(2, 16'h0000);
    chk({31'h0, irq_error}, 32'h0);
    wr(ERR_EN_ADDR, 32'h0000E000);
    chk({31'h0, irq_error}, 32'h1);
    rc(ERR_EN_ADDR, 32'hE000);
    cism_engine_model_inst.st(CISM_ERR_PASSIVE);
    cism_engine_model_inst.st(CISM_BUS_OFF);
    rc(ERR_FLAGS_ADDR, 32'h00E0);
    wr(ERR_FLAGS_ADDR, 32'h000000A0);
    rc(ERR_FLAGS_ADDR, 32'h00A0);
    wr(ERR_FLAGS_ADDR, 32'h0000);
    chk({31'h0, irq}, 32'h0);
  endtask
  // reset in mid-run with a request pending; bus off is seen again as an entry after release
  task automatic t_rerst;
    wr(SLOT_EN_ADDR, 32'h0080);
    chk({31'h0, irq_slot}, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(SLOT_FLAGS_ADDR, 32'h0);
    rc(SLOT_EN_ADDR, 32'h0);
    chk({31'h0, irq_slot}, 32'h0);
    rc(ERR_FLAGS_ADDR, 32'h0080);
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_slots();
    t_remote();
    t_race();
    t_err();
    t_rerst();
    report_and_stop();
  end
endmodule // testbench

/* verilog/cism_slot_qualify.sv */
// picks which slot completion events set a slot flag
`timescale 1ns/100ps
module cism_slot_qualify
(
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_is_tx, // slot configured for transmit
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_is_remote, // slot handles remote frames
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_auto_resp, // auto answer on remote receive slot
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_tx_done, // frame sent from slot, pulse
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_rx_stored, // frame received and stored, pulse
  output logic [cism_pkg::NUM_SLOTS-1:0] slot_set // qualified set request per slot
);
  import cism_pkg::*;

  logic [NUM_SLOTS-1:0] tx_counts;
  logic [NUM_SLOTS-1:0] rx_counts;

  always_comb
  begin
    // sends: plain transmit slots, remote transmit slots, auto answer of remote receive slots
    tx_counts = slot_is_tx | (slot_is_remote & slot_auto_resp);
    // receptions: receive slots after storage, data answer on remote transmit slots
    rx_counts = ~slot_is_tx | (slot_is_tx & slot_is_remote);
    slot_set = (slot_tx_done & tx_counts) | (slot_rx_stored & rx_counts);
  end
endmodule // cism_slot_qualify

/* verilog/cism_top.sv */
// can interrupt request status and mask registers behind an axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cism_top
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [cism_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [cism_pkg::AXI_DW-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [cism_pkg::AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [cism_pkg::AXI_DW-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_is_tx, // slot set for transmit
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_is_remote, // slot handles remote frames
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_auto_resp, // remote auto answer enabled
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_tx_done, // send finished, pulse
  input wire logic [cism_pkg::NUM_SLOTS-1:0] slot_rx_stored, // receive stored, pulse
  input wire logic bus_error_pulse, // bus error detected, pulse
  input wire cism_pkg::cism_err_state_t err_state, // fault confinement state, level
  output logic irq_slot, // slot completion request
  output logic irq_error, // error event request
  output logic irq // any request
);
  import cism_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [AXI_DW-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic [NUM_SLOTS-1:0] slot_flags;
    logic [NUM_SLOTS-1:0] slot_en;
    logic [2:0] err_flags;
    logic [2:0] err_en;
    cism_err_state_t err_prev;
    logic irq_slot;
    logic irq_err;
    logic irq_any;
  } cism_state_t;

  localparam cism_state_t STATE_RST = '{
    aw_got: 1'b0,
    aw_addr: '0,
    w_got: 1'b0,
    w_data: '0,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY,
    slot_flags: SLOT_FLAGS_RST,
    slot_en: SLOT_EN_RST,
    err_flags: ERR_FLAGS_RST,
    err_en: ERR_EN_RST,
    err_prev: CISM_ERR_ACTIVE,
    irq_slot: 1'b0,
    irq_err: 1'b0,
    irq_any: 1'b0
  };

  cism_state_t state_ff;
  cism_state_t nxt_state;
  logic [NUM_SLOTS-1:0] slot_set;
  logic [2:0] err_set;
  logic [15:0] lanes;
  logic [15:0] wr_low;
  logic do_write;
  cism_reg_sel_t wr_sel;
  cism_reg_sel_t rd_sel;

  // map a byte address onto a register
  function automatic cism_reg_sel_t decode(input logic [AXI_AW-1:0] addr);
    cism_reg_sel_t sel;
    sel = CISM_REG_NONE;
    unique case (addr)
      SLOT_FLAGS_ADDR: sel = CISM_REG_SLOT_FLAGS;
      SLOT_EN_ADDR: sel = CISM_REG_SLOT_EN;
      ERR_FLAGS_ADDR: sel = CISM_REG_ERR_FLAGS;
      ERR_EN_ADDR: sel = CISM_REG_ERR_EN;
      default: sel = CISM_REG_NONE;
    endcase
    return sel;
  endfunction

  // byte strobes widened to the 16 live bits
  function automatic logic [15:0] lane_bits(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // zero in a strobed lane clears, one or an idle lane keeps
  function automatic logic [15:0] clear_keep(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] ln
  );
    return old & (wd | ~ln);
  endfunction

  // plain read-write merge over strobed lanes
  function automatic logic [15:0] rw_merge(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] ln
  );
    return (old & ~ln) | (wd & ln);
  endfunction

  // error flags placed at their bit positions
  function automatic logic [15:0] pack_err_flags(input logic [2:0] f);
    logic [15:0] w;
    w = 16'h0000;
    w[BUS_ERR_FLAG_BIT] = f[0];
    w[ERR_PASSIVE_FLAG_BIT] = f[1];
    w[BUS_OFF_FLAG_BIT] = f[2];
    return w;
  endfunction

  // error enables placed at their bit positions
  function automatic logic [15:0] pack_err_en(input logic [2:0] e);
    logic [15:0] w;
    w = 16'h0000;
    w[BUS_ERR_EN_BIT] = e[0];
    w[ERR_PASSIVE_EN_BIT] = e[1];
    w[BUS_OFF_EN_BIT] = e[2];
    return w;
  endfunction

  // register contents as seen by a read
  function automatic logic [15:0] read_word(
    input cism_reg_sel_t sel,
    input cism_state_t s
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (sel)
      CISM_REG_SLOT_FLAGS: w = s.slot_flags;
      CISM_REG_SLOT_EN: w = s.slot_en;
      CISM_REG_ERR_FLAGS: w = pack_err_flags(s.err_flags);
      CISM_REG_ERR_EN: w = pack_err_en(s.err_en);
      CISM_REG_NONE: w = 16'h0000;
    endcase
    return w;
  endfunction

  cism_slot_qualify cism_slot_qualify_inst
  (
    .slot_is_tx(slot_is_tx),
    .slot_is_remote(slot_is_remote),
    .slot_auto_resp(slot_auto_resp),
    .slot_tx_done(slot_tx_done),
    .slot_rx_stored(slot_rx_stored),
    .slot_set(slot_set)
  );

  // handshake readies straight from state
  assign s_axi_awready = ~state_ff.aw_got & ~state_ff.bvalid;
  assign s_axi_wready = ~state_ff.w_got & ~state_ff.bvalid;
  assign s_axi_arready = ~state_ff.rvalid;

  always_comb
  begin
    nxt_state = state_ff;
    // error events; state entry seen as a change of state
    err_set[0] = bus_error_pulse;
    err_set[1] = (err_state == CISM_ERR_PASSIVE) && (state_ff.err_prev != CISM_ERR_PASSIVE);
    err_set[2] = (err_state == CISM_BUS_OFF) && (state_ff.err_prev != CISM_BUS_OFF);
    nxt_state.err_prev = err_state;
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_state.aw_got = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_state.w_got = 1'b1;
      nxt_state.w_data = s_axi_wdata;
      nxt_state.w_strb = s_axi_wstrb;
    end
    // write performed the cycle after both halves are held
    do_write = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
    wr_sel = decode(state_ff.aw_addr);
    lanes = lane_bits(state_ff.w_strb);
    wr_low = state_ff.w_data[15:0];
    if (do_write)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = (wr_sel == CISM_REG_NONE) ? RESP_DECERR : RESP_OKAY;
      unique case (wr_sel)
        CISM_REG_SLOT_FLAGS:
        begin
          nxt_state.slot_flags = clear_keep(state_ff.slot_flags, wr_low, lanes);
        end
        CISM_REG_SLOT_EN:
        begin
          nxt_state.slot_en = rw_merge(state_ff.slot_en, wr_low, lanes);
        end
        CISM_REG_ERR_FLAGS:
        begin
          // reserved bits 0 to 4 ignore the write
          if (state_ff.w_strb[0])
          begin
            nxt_state.err_flags = state_ff.err_flags & wr_low[BUS_OFF_FLAG_BIT:BUS_ERR_FLAG_BIT];
          end
        end
        CISM_REG_ERR_EN:
        begin
          // reserved bits 8 to 12 ignore the write
          if (state_ff.w_strb[1])
          begin
            nxt_state.err_en = wr_low[BUS_OFF_EN_BIT:BUS_ERR_EN_BIT];
          end
        end
        CISM_REG_NONE:
        begin
          nxt_state.bresp = RESP_DECERR;
        end
      endcase
    end
    if (state_ff.bvalid && s_axi_bready)
    begin
      nxt_state.bvalid = 1'b0;
    end
    // hardware sets applied last so they beat a clear, whatever the enables
    nxt_state.slot_flags = nxt_state.slot_flags | slot_set;
    nxt_state.err_flags = nxt_state.err_flags | err_set;
    // read answered from registered state
    rd_sel = decode(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = {16'h0000, read_word(rd_sel, state_ff)};
      nxt_state.rresp = (rd_sel == CISM_REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    else if (state_ff.rvalid && s_axi_rready)
    begin
      nxt_state.rvalid = 1'b0;
    end
    // group requests from next flags and enables
    nxt_state.irq_slot = |(nxt_state.slot_flags & nxt_state.slot_en);
    nxt_state.irq_err = |(nxt_state.err_flags & nxt_state.err_en);
    nxt_state.irq_any = nxt_state.irq_slot | nxt_state.irq_err;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;
  assign irq_slot = state_ff.irq_slot;
  assign irq_error = state_ff.irq_err;
  assign irq = state_ff.irq_any;
endmodule // cism_top
